// ---- bus_cycle.sv ----
`timescale 1ns/10ps
module bus_cycle
  import flash_cmd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // request
  input wire logic start,
  input wire logic is_read,
  input wire logic [flash_cmd_pkg::ADDR_WIDTH-1:0] addr,
  input wire logic [flash_cmd_pkg::DATA_WIDTH-1:0] wdata,
  output logic done,
  output logic [flash_cmd_pkg::DATA_WIDTH-1:0] rdata,
  // flash pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [flash_cmd_pkg::ADDR_WIDTH-1:0] flash_addr,
  output logic [flash_cmd_pkg::DATA_WIDTH-1:0] dq_out,
  output logic dq_oe,
  input wire logic [flash_cmd_pkg::DATA_WIDTH-1:0] dq_in
);
  import flash_cmd_pkg::*;
  typedef enum logic [1:0] {IDLE, SETUP, STROBE, RECOVER} phase_type;
  phase_type phase, next_phase;
  logic [3:0] count, next_count;
  logic rd, next_rd;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic [ADDR_WIDTH-1:0] next_flash_addr;
  logic [DATA_WIDTH-1:0] next_dq_out;

  always_comb begin
    next_phase = phase;
    next_count = count;
    next_rd = rd;
    next_rdata = rdata;
    next_flash_addr = flash_addr;
    next_dq_out = dq_out;
    done = 1'b0;
    unique case (phase)
      IDLE: if (start) begin
        next_phase = SETUP;
        next_rd = is_read;
        next_flash_addr = addr;
        next_dq_out = wdata;
        next_count = PHASE_CYCLES;
      end
      SETUP: begin
        // address settles before the strobe falls, so the later falling edge sees it
        next_phase = STROBE;
        next_count = PHASE_CYCLES;
      end
      STROBE: if (count == 4'h1) begin
        next_phase = RECOVER;
        next_count = PHASE_CYCLES;
        if (rd) next_rdata = dq_in;
      end else begin
        next_count = count - 4'h1;
      end
      RECOVER: if (count == 4'h1) begin
        next_phase = IDLE;
        done = 1'b1;
      end else begin
        next_count = count - 4'h1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phase <= IDLE;
      count <= 4'h0;
      rd <= 1'b0;
      rdata <= '0;
      flash_addr <= '0;
      dq_out <= '0;
    end else begin
      phase <= next_phase;
      count <= next_count;
      rd <= next_rd;
      rdata <= next_rdata;
      flash_addr <= next_flash_addr;
      dq_out <= next_dq_out;
    end
  end

  // both strobes rise together and data is held through recovery
  assign ce_n = !(phase == SETUP || phase == STROBE);
  assign we_n = !(phase == STROBE && !rd);
  assign oe_n = !(phase == STROBE && rd);
  assign dq_oe = !rd && phase != IDLE;

  property p_strobe_len;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(we_n) |-> !we_n [*8] ##1 we_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("write strobe too short");

  property p_data_hold;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(we_n) |-> $stable(dq_out) && dq_oe;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");

  property p_addr_setup;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(we_n) |-> $stable(flash_addr) && !$past(ce_n);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("address not set up");
endmodule

// ---- flash_cmd_host.sv ----
`timescale 1ns/10ps
// Summary of operation
// - commands of three or more cycles open with AA/555, 55/2AA
// - lost sequences recover by F0 anywhere
// - reset leaves identification or timed-out status
// - 90 then reads at identification offsets
// - program: unlocks, A0, location and word
// - buffer: 25, count-1, pairs, 29 confirm
// - buffer locations stay in starting page; the host counts up from the start with no wrap at the page end
// - abort reset: unlocks then F0 at 555
// - bypass: 20 enter; A0, 80/30, 80/10
// - bypass exit is 90 then 00
// - erase: unlocks, 80, unlocks, 10 or 30
// - secured entry 88; exit 90 then 00
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int BUF_DEPTH = flash_cmd_pkg::BUF_WORDS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // command request
  input wire logic req_valid,
  output logic req_ready,
  input flash_cmd_pkg::op_type req_op,
  input wire logic [flash_cmd_pkg::ADDR_WIDTH-1:0] req_addr,
  input wire logic [flash_cmd_pkg::DATA_WIDTH-1:0] req_data,
  input wire logic [5:0] req_count,
  input wire logic secure_exit,
  // buffered program words
  input wire logic [flash_cmd_pkg::DATA_WIDTH-1:0] buf_word [BUF_DEPTH],
  // answer
  output logic resp_valid,
  output logic [flash_cmd_pkg::DATA_WIDTH-1:0] resp_data,
  output logic in_bypass,
  output logic in_ident,
  output logic erasing,
  output logic suspended,
  // flash pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [flash_cmd_pkg::ADDR_WIDTH-1:0] flash_addr,
  output logic [flash_cmd_pkg::DATA_WIDTH-1:0] dq_out,
  output logic dq_oe,
  input wire logic [flash_cmd_pkg::DATA_WIDTH-1:0] dq_in
);
  import flash_cmd_pkg::*;
  typedef enum logic [1:0] {IDLE, ISSUE, WAIT} seq_type;
  seq_type state, next_state;
  op_type op, next_op;
  logic [5:0] step, next_step;
  logic [5:0] last, next_last;
  logic [ADDR_WIDTH-1:0] base, next_base;
  logic [DATA_WIDTH-1:0] word, next_word;
  logic [5:0] words, next_words;
  logic next_in_bypass, next_in_ident, next_erasing, next_suspended, exit_mode, next_exit_mode;
  logic [DATA_WIDTH-1:0] next_resp_data;
  logic next_resp_valid;
  logic cyc_start, cyc_read, cyc_done;
  logic [ADDR_WIDTH-1:0] cyc_addr;
  logic [DATA_WIDTH-1:0] cyc_data;
  logic [DATA_WIDTH-1:0] cyc_rdata;
  logic legal;

  // sector address: upper bits kept, lower 16 cleared, for buffer and sector-erase command cycles
  function automatic logic [ADDR_WIDTH-1:0] sector_of(input logic [ADDR_WIDTH-1:0] a);
    sector_of = {a[ADDR_WIDTH-1:SECTOR_LSB], 16'h0000};
  endfunction

  function automatic logic [DATA_WIDTH-1:0] cmd(input logic [7:0] c);
    cmd = {8'h00, c};
  endfunction

  // refuse what the device would not accept in its present mode
  always_comb begin
    unique case (req_op)
      OP_CFI: legal = !erasing && !suspended && !in_bypass;
      OP_SUSPEND: legal = erasing && !suspended;
      OP_RESUME: legal = suspended;
      OP_BYPASS_PROGRAM, OP_BYPASS_SECTOR_ERASE, OP_BYPASS_CHIP_ERASE,
      OP_BYPASS_EXIT: legal = in_bypass;
      OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_BYPASS_ENTER: legal = !suspended && !in_bypass;
      default: legal = 1'b1;
    endcase
  end
  assign req_ready = state == IDLE;

  // one step per bus cycle; step picks address and data
  always_comb begin
    cyc_read = 1'b0;
    cyc_addr = UNLOCK1_ADDR;
    cyc_data = cmd(UNLOCK1_DATA);
    if (step == 6'd1 || (step == 6'd4 && op == OP_CHIP_ERASE) ||
        (step == 6'd4 && op == OP_SECTOR_ERASE)) begin
      cyc_addr = UNLOCK2_ADDR;
      cyc_data = cmd(UNLOCK2_DATA);
    end
    unique case (op)
      OP_RESET: cyc_data = cmd(CMD_RESET);
      OP_READ: begin
        cyc_read = 1'b1;
        cyc_addr = base;
      end
      OP_CFI: begin
        cyc_addr = CFI_ADDR;
        cyc_data = cmd(CMD_CFI);
      end
      OP_ID_ENTER: begin
        if (step == 6'd2) cyc_data = cmd(CMD_IDENT);
        if (step == 6'd3) begin
          cyc_read = !exit_mode;
          cyc_addr = exit_mode ? '0 : base;
          cyc_data = cmd(CMD_EXIT_DATA);
        end
      end
      OP_PROGRAM, OP_BYPASS_PROGRAM: begin
        if (step == last - 6'd1) cyc_data = cmd(CMD_PROGRAM);
        if (step == last) begin
          cyc_addr = base;
          cyc_data = word;
        end
      end
      OP_BUF_PROGRAM: begin
        if (step == 6'd2) begin
          cyc_addr = sector_of(base);
          cyc_data = cmd(CMD_BUF_LOAD);
        end else if (step == 6'd3) begin
          cyc_addr = sector_of(base);
          cyc_data = {10'h000, words};
        end else if (step == last) begin
          cyc_addr = sector_of(base);
          cyc_data = cmd(CMD_BUF_CONFIRM);
        end else if (step > 6'd3) begin
          // locations count up from the start, with no wrap at the page end
          cyc_addr = base + ADDR_WIDTH'(step - 6'd4);
          cyc_data = buf_word[5'(step - 6'd4)];
        end
      end
      OP_ABORT_RESET: if (step == 6'd2) cyc_data = cmd(CMD_RESET);
      OP_BYPASS_ENTER: if (step == 6'd2)
        cyc_data = cmd(exit_mode ? CMD_SECURE_ENTRY : CMD_BYPASS);
      OP_BYPASS_SECTOR_ERASE: begin
        cyc_data = cmd(step == 6'd0 ? CMD_ERASE_SETUP : CMD_SECTOR_ERASE);
        if (step == 6'd1) cyc_addr = sector_of(base);
      end
      OP_BYPASS_CHIP_ERASE: cyc_data = cmd(step == 6'd0 ? CMD_ERASE_SETUP : CMD_CHIP_ERASE);
      OP_BYPASS_EXIT: cyc_data = cmd(step == 6'd0 ? CMD_IDENT : CMD_EXIT_DATA);
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        if (step == 6'd2) cyc_data = cmd(CMD_ERASE_SETUP);
        if (step == 6'd5) begin
          cyc_data = cmd(op == OP_CHIP_ERASE ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE);
          if (op == OP_SECTOR_ERASE) cyc_addr = sector_of(base);
        end
      end
      OP_SUSPEND: cyc_data = cmd(CMD_SUSPEND);
      OP_RESUME: cyc_data = cmd(CMD_RESUME);
    endcase
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_last = last;
    next_base = base;
    next_word = word;
    next_words = words;
    next_exit_mode = exit_mode;
    next_in_bypass = in_bypass;
    next_in_ident = in_ident;
    next_erasing = erasing;
    next_suspended = suspended;
    next_resp_valid = 1'b0;
    next_resp_data = resp_data;
    cyc_start = 1'b0;
    unique case (state)
      IDLE: if (req_valid) begin
        if (!legal) begin
          // refused requests answer at once with no bus activity
          next_resp_valid = 1'b1;
          next_resp_data = '1;
        end else begin
          next_state = ISSUE;
          next_op = req_op;
          next_base = req_addr;
          next_word = req_data;
          next_words = req_count;
          next_step = 6'd0;
          next_exit_mode = secure_exit;
          // secured entry is the bypass-enter shape with another code
          unique case (req_op)
            OP_RESET, OP_READ, OP_CFI, OP_SUSPEND, OP_RESUME: next_last = 6'd0;
            OP_BYPASS_PROGRAM, OP_BYPASS_SECTOR_ERASE, OP_BYPASS_CHIP_ERASE,
            OP_BYPASS_EXIT: next_last = 6'd1;
            OP_ABORT_RESET, OP_BYPASS_ENTER: next_last = 6'd2;
            OP_ID_ENTER, OP_PROGRAM: next_last = 6'd3;
            OP_BUF_PROGRAM: next_last = req_count + 6'd5;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: next_last = 6'd5;
          endcase
        end
      end
      ISSUE: begin
        cyc_start = 1'b1;
        next_state = WAIT;
      end
      WAIT: if (cyc_done) begin
        if (step == last) begin
          next_state = IDLE;
          next_resp_valid = 1'b1;
          next_resp_data = cyc_read ? cyc_rdata : '0;
          unique case (op)
            OP_RESET: begin
              next_in_ident = 1'b0;
              next_erasing = 1'b0;
            end
            OP_ID_ENTER: next_in_ident = !exit_mode;
            OP_BYPASS_ENTER: next_in_bypass = !exit_mode;
            OP_BYPASS_EXIT: next_in_bypass = 1'b0;
            OP_SECTOR_ERASE, OP_BYPASS_SECTOR_ERASE: next_erasing = 1'b1;
            OP_SUSPEND: next_suspended = 1'b1;
            OP_RESUME: next_suspended = 1'b0;
            default: next_in_ident = in_ident;
          endcase
        end else begin
          next_step = step + 6'd1;
          next_state = ISSUE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= IDLE;
      op <= OP_RESET;
      step <= 6'd0;
      last <= 6'd0;
      base <= '0;
      word <= '0;
      words <= 6'd0;
      exit_mode <= 1'b0;
      in_bypass <= 1'b0;
      in_ident <= 1'b0;
      erasing <= 1'b0;
      suspended <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      last <= next_last;
      base <= next_base;
      word <= next_word;
      words <= next_words;
      exit_mode <= next_exit_mode;
      in_bypass <= next_in_bypass;
      in_ident <= next_in_ident;
      erasing <= next_erasing;
      suspended <= next_suspended;
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
    end
  end

  bus_cycle u_cycle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .flash_addr(flash_addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dq_in(dq_in)
  );

  property p_unlock_first;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && step == 6'd0 && last > 6'd1 |-> cyc_addr == UNLOCK1_ADDR && cyc_data == 16'h00AA;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("sequence not unlocked");

  property p_low_byte;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && !cyc_read && op != OP_PROGRAM && op != OP_BYPASS_PROGRAM
      && op != OP_BUF_PROGRAM |-> cyc_data[15:8] == 8'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("upper command byte set");

  property p_suspend_ok;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && op == OP_SUSPEND |-> erasing && !suspended;
  endproperty
  a_suspend_ok: assert property (p_suspend_ok) else $error("suspend outside erase");

  property p_resume_ok;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && op == OP_RESUME |-> suspended;
  endproperty
  a_resume_ok: assert property (p_resume_ok) else $error("resume while not suspended");

  property p_cfi_ok;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && op == OP_CFI |-> cyc_addr == CFI_ADDR && !erasing && !in_bypass;
  endproperty
  a_cfi_ok: assert property (p_cfi_ok) else $error("query issued when not ready");

  property p_step_done;
    @(posedge core_clk) disable iff (sys_rst)
      state == WAIT && cyc_done && step != last |=> state == ISSUE && step == $past(step) + 6'd1;
  endproperty
  a_step_done: assert property (p_step_done) else $error("step did not advance");

  property p_bypass_exit;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(in_bypass) |-> $past(op) == OP_BYPASS_EXIT;
  endproperty
  a_bypass_exit: assert property (p_bypass_exit) else $error("bypass left without exit");

  property p_confirm;
    @(posedge core_clk) disable iff (sys_rst)
      cyc_start && op == OP_BUF_PROGRAM && step == last |-> cyc_data == 16'h0029;
  endproperty
  a_confirm: assert property (p_confirm) else $error("buffer not confirmed");
endmodule

// ---- flash_cmd_pkg.sv ----
package flash_cmd_pkg;
  localparam int ADDR_WIDTH = 26;
  localparam int DATA_WIDTH = 16;
  localparam logic [ADDR_WIDTH-1:0] UNLOCK1_ADDR = 26'h0000555;
  localparam logic [ADDR_WIDTH-1:0] UNLOCK2_ADDR = 26'h00002AA;
  localparam logic [ADDR_WIDTH-1:0] CFI_ADDR = 26'h0000055;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_CFI = 8'h98;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CMD_EXIT_DATA = 8'h00;
  localparam logic [7:0] ID_MAKER = 8'h00;
  localparam logic [7:0] ID_PROTECT = 8'h02;
  localparam logic [7:0] ID_SECURE = 8'h03;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam int TOP_DATA_BIT = 7;
  localparam int SECTOR_LSB = 16;
  localparam int BUF_WORDS = 32;
  localparam int SETUP_NS = 30;
  localparam int CLK_NS = 4;
  localparam logic [3:0] PHASE_CYCLES = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [3:0] {
    OP_RESET, OP_READ, OP_ID_ENTER, OP_CFI, OP_PROGRAM, OP_BUF_PROGRAM,
    OP_ABORT_RESET, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_SECTOR_ERASE,
    OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE,
    OP_SUSPEND, OP_RESUME
  } op_type;
endpackage

// ---- flash_model.sv ----
`timescale 1ns/10ps
module flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h00B7, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h1234, // arbitrary value
  parameter logic [9:0] PROT_SECTOR = 10'h003,
  parameter logic SECURED = 1'b1
) (
  // flash pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [25:0] flash_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in
);
  logic [25:0] lat_addr;
  logic [25:0] log_addr [64];
  logic [15:0] log_data [64];
  int log_n = 0;
  int pos = 0;
  logic wr_act = 1'b0;
  logic ident = 1'b0;
  logic cfi = 1'b0;
  logic [15:0] rd_val;
  logic [15:0] hold = 16'hA5A5;
  task automatic decode(input logic [15:0] a, input logic [7:0] d);
    if (d == 8'hF0 && pos != 2) begin
      pos = 0;
      cfi = 1'b0;
      ident = 1'b0;
    end else if (ident && d == 8'h00 && pos == 0) begin
      ident = 1'b0;
    end else if (pos == 0) begin
      pos = (a == 16'h0555 && d == 8'hAA) ? 1 : 0;
      if (a == 16'h0055 && d == 8'h98) cfi = 1'b1;
    end else if (pos == 1) begin
      pos = (a == 16'h02AA && d == 8'h55) ? 2 : 0;
    end else begin
      pos = 0;
      if (d == 8'h90) ident = 1'b1;
      if (d == 8'hF0) ident = 1'b0;
    end
  endtask
  // address on the later falling strobe
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n) begin
      lat_addr = flash_addr;
      wr_act = 1'b1;
    end
  end
  // data on the first rising strobe; the second edge finds wr_act clear
  always @(posedge we_n or posedge ce_n) begin
    if (wr_act) begin
      wr_act = 1'b0;
      log_addr[log_n % 64] = lat_addr;
      log_data[log_n % 64] = dq_out;
      log_n++;
      decode(lat_addr[15:0], dq_out[7:0]);
    end
  end
  always_comb begin
    rd_val = flash_addr[15:0] ^ 16'hC3A5;
    if (ident) begin
      case (flash_addr[7:0])
        8'h00: rd_val = MAKER_ID;
        8'h01, 8'h0E, 8'h0F: rd_val = DEVICE_ID;
        8'h02: rd_val = {15'h0000, flash_addr[25:16] == PROT_SECTOR};
        8'h03: rd_val = {8'h00, SECURED, 7'h00};
        default: rd_val = 16'h0000;
      endcase
    end
  end
  // no pull-ups: a released bus shows the inverse of its last value
  always @(negedge dq_oe) hold = ~dq_out;
  always @(posedge oe_n or posedge ce_n) hold = ~rd_val;
  assign dq_in = dq_oe ? dq_out : ((!ce_n && !oe_n) ? rd_val : hold);
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  import flash_cmd_pkg::*;
  localparam logic [15:0] MAKER = 16'h00B7; // arbitrary value
  localparam logic [15:0] DEVID = 16'h1234; // arbitrary value
  localparam logic [9:0] PSEC = 10'h003;
  localparam logic [25:0] DC = '1;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  op_type req_op = OP_READ;
  logic [25:0] req_addr = '0;
  logic [15:0] req_data = '0;
  logic [5:0] req_count = '0;
  logic secure_exit = 1'b0;
  logic [15:0] bw [32];
  logic req_ready, resp_valid, in_bypass, in_ident, erasing, suspended;
  logic ce_n, we_n, oe_n, dq_oe;
  logic [15:0] resp_data, dq_out, dq_in, got;
  logic [25:0] flash_addr;
  logic [25:0] qa [$];
  logic [15:0] qd [$];
  int n_fail = 0;
  int check_count = 0;
  always #2 core_clk = ~core_clk;
  flash_cmd_host #(.BUF_DEPTH(32)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .req_count(req_count), .secure_exit(secure_exit), .buf_word(bw),
    .resp_valid(resp_valid), .resp_data(resp_data), .in_bypass(in_bypass),
    .in_ident(in_ident), .erasing(erasing), .suspended(suspended), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));
  flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVID), .PROT_SECTOR(PSEC)) partner (
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .flash_addr(flash_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ex(input logic [25:0] a, input logic [15:0] d);
    qa.push_back(a);
    qd.push_back(d);
  endtask
  // both unlocks, then a command at the first unlock address
  task automatic u3(input logic [15:0] d);
    ex(26'h555, 16'hAA);
    ex(26'h2AA, 16'h55);
    ex(26'h555, d);
  endtask
  // one request; the writes it caused must match the queued list
  task automatic run(input op_type op, input logic [25:0] a, input logic [15:0] d);
    int n;
    int k;
    int base;
    base = partner.log_n;
    @(negedge core_clk);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      req_valid = 1'b0;
      n++;
    end while (resp_valid !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      n_fail++;
      $display("CHECK FAILED resp_valid exp 1 got 0");
      end_of_test();
    end
    got = resp_data;
    `CHK("writes", qa.size(), partner.log_n - base)
    foreach (qa[i]) begin
      k = (base + i) % 64;
      if (qa[i] != DC) `CHK("addr", qa[i][15:0], partner.log_addr[k][15:0])
      if (qa[i][25:16] != 0 && qa[i] != DC) `CHK("sector", qa[i], partner.log_addr[k])
      `CHK("data", qd[i][7:0], partner.log_data[k][7:0])
      if (qd[i][15:8] != 0) `CHK("word", qd[i], partner.log_data[k])
    end
    qa.delete();
    qd.delete();
  endtask
  task automatic refuse(input op_type op);
    run(op, '0, '0);
    `CHK("refused", 16'hFFFF, got)
  endtask
  task automatic rst_cmd();
    ex(DC, 16'hF0);
    run(OP_RESET, '0, '0);
  endtask
  task automatic t_read_cfi();
    `CHK("idle strobe", 1'b1, we_n)
    `CHK("ready", 1'b1, req_ready)
    `CHK("bus released", 1'b0, dq_oe)
    run(OP_READ, 26'h0012345, '0);
    `CHK("array", 16'h2345 ^ 16'hC3A5, got)
    ex(26'h055, 16'h98);
    run(OP_CFI, '0, '0);
    `CHK("query", 1'b1, partner.cfi)
    rst_cmd();
    `CHK("query left", 1'b0, partner.cfi)
    $display("test read and query done");
  endtask
  task automatic t_ident();
    logic [25:0] off [5] = '{26'h0, 26'h1, {PSEC, 16'h0002}, 26'h2, 26'h3};
    logic [15:0] val [5] = '{MAKER, DEVID, 16'h0001, 16'h0000, 16'h0080};
    for (int i = 0; i < 5; i++) begin
      u3(16'h90);
      run(OP_ID_ENTER, off[i], '0);
      `CHK("ident", val[i], got)
      `CHK("in_ident", 1'b1, in_ident)
    end
    rst_cmd();
    `CHK("left ident", 1'b0, in_ident)
    run(OP_READ, 26'h0000100, '0);
    `CHK("array", 16'h0100 ^ 16'hC3A5, got)
    secure_exit = 1'b1;
    u3(16'h88);
    run(OP_BYPASS_ENTER, '0, '0);
    `CHK("secured not bypass", 1'b0, in_bypass)
    u3(16'h90);
    ex(DC, 16'h00);
    run(OP_ID_ENTER, '0, '0);
    secure_exit = 1'b0;
    `CHK("secured exit", 1'b0, in_ident)
    `CHK("device exit", 1'b0, partner.ident)
    $display("test identification done");
  endtask
  task automatic t_program();
    u3(16'hA0);
    ex(26'h1230042, 16'h5A3C);
    run(OP_PROGRAM, 26'h1230042, 16'h5A3C);
    req_count = 6'd2;
    ex(DC, 16'hAA);
    ex(DC, 16'h55);
    ex(26'h0450000, 16'h25);
    ex(26'h0450000, 16'h02);
    for (int i = 0; i < 3; i++) ex(26'h0450000 + 26'(i), bw[i]);
    ex(26'h0450000, 16'h29);
    run(OP_BUF_PROGRAM, 26'h0450000, '0);
    u3(16'hF0);
    run(OP_ABORT_RESET, '0, '0);
    $display("test program done");
  endtask
  task automatic t_bypass();
    refuse(OP_BYPASS_PROGRAM);
    u3(16'h20);
    run(OP_BYPASS_ENTER, '0, '0);
    `CHK("bypass", 1'b1, in_bypass)
    refuse(OP_CFI);
    ex(DC, 16'hA0);
    ex(26'h2340008, 16'hC3C3);
    run(OP_BYPASS_PROGRAM, 26'h2340008, 16'hC3C3);
    ex(DC, 16'h80);
    ex(DC, 16'h10);
    run(OP_BYPASS_CHIP_ERASE, '0, '0);
    ex(DC, 16'h80);
    ex(26'h2340000, 16'h30);
    run(OP_BYPASS_SECTOR_ERASE, 26'h2340000, '0);
    ex(DC, 16'h90);
    ex(DC, 16'h00);
    run(OP_BYPASS_EXIT, '0, '0);
    `CHK("bypass", 1'b0, in_bypass)
    rst_cmd();
    $display("test bypass done");
  endtask
  task automatic t_erase();
    refuse(OP_SUSPEND);
    refuse(OP_RESUME);
    u3(16'h80);
    ex(26'h555, 16'hAA);
    ex(26'h2AA, 16'h55);
    ex(26'h3010000, 16'h30);
    run(OP_SECTOR_ERASE, 26'h3010000, '0);
    `CHK("erasing", 1'b1, erasing)
    refuse(OP_CFI);
    ex(DC, 16'hB0);
    run(OP_SUSPEND, '0, '0);
    `CHK("suspended", 1'b1, suspended)
    refuse(OP_SUSPEND);
    ex(DC, 16'h30);
    run(OP_RESUME, '0, '0);
    `CHK("suspended", 1'b0, suspended)
    rst_cmd();
    u3(16'h80);
    u3(16'h10);
    run(OP_CHIP_ERASE, '0, '0);
    rst_cmd();
    $display("test erase done");
  endtask
  initial begin
    for (int i = 0; i < 32; i++) bw[i] = 16'hB100 + 16'(i);
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    t_read_cfi();
    t_ident();
    t_program();
    t_bypass();
    t_erase();
    end_of_test();
  end
endmodule
